// file: rtl/pch_pkg.sv
// Constants for the configuration identity and command registers
package pch_pkg;
  localparam int unsigned CFG_AW          = 6;
  localparam logic [5:0]  DW_IDENT        = 6'h00;
  localparam logic [5:0]  DW_CMD_STATUS   = 6'h01;
  localparam logic [7:0]  OFS_MAKER_ID    = 8'h00;
  localparam logic [7:0]  OFS_PART_ID     = 8'h02;
  localparam logic [7:0]  OFS_COMMAND     = 8'h04;
  localparam logic [15:0] CMD_RESET       = 16'h0000;
  localparam logic [15:0] CMD_WRITABLE    = 16'h0147;
  localparam int unsigned BIT_IO_EN       = 0;
  localparam int unsigned BIT_MEM_EN      = 1;
  localparam int unsigned BIT_INIT_EN     = 2;
  localparam int unsigned BIT_SPECIAL     = 3;
  localparam int unsigned BIT_WINV_EN     = 4;
  localparam int unsigned BIT_PALETTE     = 5;
  localparam int unsigned BIT_PARITY_EN   = 6;
  localparam int unsigned BIT_STEP_EN     = 7;
  localparam int unsigned BIT_SYSTEM_ERROR_REPORT_ENABLE     = 8;
  localparam int unsigned BIT_B2B_EN      = 9;
  localparam int unsigned RSVD_LSB        = 10;
  localparam int unsigned RSVD_MSB        = 15;
endpackage

// file: rtl/pch_config_regs.sv
// Configuration identity words and command register with their effects
`timescale 1ns/100ps
// How it works
// - Offset 0 returns a fixed read-only maker code; writes leave it alone.
// - Offset 2 returns a fixed read-only part code chosen by the maker.
// - Offset 4 holds the 16-bit command register, all zeros after reset.
// - Command bits 15..10 are reserved, read zero, ignore writes.
// - Command bit 9, back-to-back enable, always reads zero.
// - Command bit 8 is read/write and enables the system-error output driver.
// - Address parity errors raise system error only with bits 8 and 6 set.
// - Command bit 7, stepping control, is hardwired zero; writes do nothing.
// - Bit 6 enables parity response: data errors on PERR, address on SERR.
// - Command bit 5, palette snoop, reads zero and ignores writes.
// - Command bit 4, write-invalidate enable, reads zero; plain writes used instead.
// - Command bit 3, special cycles, reads zero; special cycles never answered.
// - Bus ownership may be requested only while command bit 2 is set.
// - Memory space cycles are claimed only while command bit 1 is set.
// - I/O space cycles are claimed only while command bit 0 is set.
module pch_config_regs #(
  parameter logic [15:0] MAKER_ID = 16'h1234,  // Arbitrary value
  parameter logic [15:0] PART_ID  = 16'h5678   // Arbitrary value
) (
  input  wire logic                       I_CLK,
  input  wire logic                       I_RST_B,
  input  wire logic                       i_cfg_rd,
  input  wire logic                       i_cfg_wr,
  input  wire logic [pch_pkg::CFG_AW-1:0] i_cfg_dw,
  input  wire logic [3:0]                 i_cfg_be,
  input  wire logic [31:0]                i_cfg_wdata,
  output logic      [31:0]                o_cfg_rdata,
  output logic                            o_cfg_ack,
  input  wire logic                       i_addr_par_err,
  input  wire logic                       i_data_par_err,
  input  wire logic                       i_mem_hit,
  input  wire logic                       i_io_hit,
  input  wire logic                       i_bus_want,
  output logic                            o_serr_drv_en,
  output logic                            o_serr,
  output logic                            o_perr,
  output logic                            o_mem_claim,
  output logic                            o_io_claim,
  output logic                            o_bus_req
);

  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic [15:0] lane_mask;
  logic        cmd_wr;
  logic [31:0] rdata_d;

  // Byte enables 0 and 1 cover the command half of the second word
  assign lane_mask = {{8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
  assign cmd_wr    = i_cfg_wr && (i_cfg_dw == pch_pkg::DW_CMD_STATUS);

  // Only writable bits ever take a one, so hardwired bits stay zero
  always_comb begin
    cmd_d = (cmd_q & ~lane_mask) | (i_cfg_wdata[15:0] & lane_mask);
    cmd_d = cmd_d & pch_pkg::CMD_WRITABLE;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      cmd_q <= pch_pkg::CMD_RESET;
    end else if (cmd_wr) begin
      cmd_q <= cmd_d;
    end
  end

  // Identity word is constant, so writes to it fall on nothing
  // Status half is outside this block and reads as zero here
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (i_cfg_dw)
      pch_pkg::DW_IDENT:      rdata_d = {PART_ID, MAKER_ID};
      pch_pkg::DW_CMD_STATUS: rdata_d = {16'h0000, cmd_q};
      default:                rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      o_cfg_rdata <= 32'h0000_0000;
      o_cfg_ack   <= 1'b0;
    end else begin
      o_cfg_ack   <= i_cfg_rd || i_cfg_wr;
      o_cfg_rdata <= i_cfg_rd ? rdata_d : 32'h0000_0000;
    end
  end

  // Error reporting; one-cycle pulses follow the detector by one clock
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      o_serr_drv_en <= 1'b0;
      o_serr        <= 1'b0;
      o_perr        <= 1'b0;
    end else begin
      o_serr_drv_en <= cmd_q[pch_pkg::BIT_SYSTEM_ERROR_REPORT_ENABLE];
      o_serr        <= i_addr_par_err && cmd_q[pch_pkg::BIT_SYSTEM_ERROR_REPORT_ENABLE]
                       && cmd_q[pch_pkg::BIT_PARITY_EN];
      o_perr        <= i_data_par_err && cmd_q[pch_pkg::BIT_PARITY_EN];
    end
  end

  // Decoder hits and initiator requests gated by the space and master enables
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      o_mem_claim <= 1'b0;
      o_io_claim  <= 1'b0;
      o_bus_req   <= 1'b0;
    end else begin
      o_mem_claim <= i_mem_hit && cmd_q[pch_pkg::BIT_MEM_EN];
      o_io_claim  <= i_io_hit && cmd_q[pch_pkg::BIT_IO_EN];
      o_bus_req   <= i_bus_want && cmd_q[pch_pkg::BIT_INIT_EN];
    end
  end

  AST_MAKER_ID: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_cfg_rd && i_cfg_dw == pch_pkg::DW_IDENT |=> o_cfg_rdata[15:0] == MAKER_ID)
    else $error("maker code wrong on read");

  AST_PART_ID: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_cfg_rd && i_cfg_dw == pch_pkg::DW_IDENT |=> o_cfg_ack && o_cfg_rdata[31:16] == PART_ID)
    else $error("part code wrong on read");

  AST_CMD_RESET: assert property (@(posedge I_CLK)
    !I_RST_B |=> cmd_q == pch_pkg::CMD_RESET && !o_mem_claim && !o_io_claim && !o_bus_req)
    else $error("command not cleared by reset");

  AST_RSVD_ZERO: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_cfg_rd && i_cfg_dw == pch_pkg::DW_CMD_STATUS
    |=> o_cfg_rdata[pch_pkg::RSVD_MSB:pch_pkg::RSVD_LSB] == 6'h00)
    else $error("reserved command bits read nonzero");

  AST_B2B_ZERO: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    cmd_wr ##2 (i_cfg_rd && i_cfg_dw == pch_pkg::DW_CMD_STATUS)
    |=> !o_cfg_rdata[pch_pkg::BIT_B2B_EN])
    else $error("back-to-back bit reads one");

  AST_SERR_DRV: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    cmd_wr && i_cfg_be[1] ##1 1'b1 |=> o_serr_drv_en == $past(i_cfg_wdata[8], 2))
    else $error("driver enable does not follow bit 8");

  AST_SERR_GATE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_addr_par_err |=> o_serr == ($past(cmd_q[pch_pkg::BIT_SYSTEM_ERROR_REPORT_ENABLE])
                                  && $past(cmd_q[pch_pkg::BIT_PARITY_EN])))
    else $error("system error gating wrong");

  AST_FIXED_ZERO: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    cmd_wr ##2 (i_cfg_rd && i_cfg_dw == pch_pkg::DW_CMD_STATUS)
    |=> o_cfg_rdata[7] == 1'b0 && o_cfg_rdata[5:3] == 3'h0)
    else $error("hardwired command bit reads one");

  AST_PERR_GATE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !cmd_q[pch_pkg::BIT_PARITY_EN] |=> !o_perr && !o_serr)
    else $error("parity reported while response disabled");

  AST_INIT_GATE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    o_bus_req |-> $past(cmd_q[pch_pkg::BIT_INIT_EN]) && $past(i_bus_want))
    else $error("bus requested while initiator disabled");

  AST_MEM_GATE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_mem_hit && cmd_q[pch_pkg::BIT_MEM_EN] |=> o_mem_claim)
    else $error("enabled memory hit not claimed");

  AST_IO_GATE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    o_io_claim |-> $past(cmd_q[pch_pkg::BIT_IO_EN]))
    else $error("io cycle claimed while disabled");

  AST_BYTE_LANE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    cmd_wr && !i_cfg_be[0] |=> cmd_q[7:0] == $past(cmd_q[7:0]))
    else $error("disabled byte lane was written");

  AST_READBACK: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    cmd_wr && i_cfg_be[0] |=> cmd_q[2:0] == $past(i_cfg_wdata[2:0]))
    else $error("written enable bits not held");

  // Bus handshake: every access is answered exactly one cycle later
  AST_ACK_PULSE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_cfg_rd || i_cfg_wr |=> o_cfg_ack)
    else $error("access not acknowledged");

  AST_ACK_IDLE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !i_cfg_rd && !i_cfg_wr |=> !o_cfg_ack)
    else $error("acknowledge without access");

  AST_RDATA_IDLE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !i_cfg_rd |=> o_cfg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");

  AST_UNMAPPED_ZERO: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_cfg_rd && i_cfg_dw != pch_pkg::DW_IDENT && i_cfg_dw != pch_pkg::DW_CMD_STATUS
    |=> o_cfg_rdata == 32'h0000_0000)
    else $error("unmapped word reads nonzero");

  AST_STATUS_HALF: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_cfg_rd && i_cfg_dw == pch_pkg::DW_CMD_STATUS |=> o_cfg_rdata[31:16] == 16'h0000)
    else $error("status half reads nonzero");

  AST_CMD_RDATA: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_cfg_rd && i_cfg_dw == pch_pkg::DW_CMD_STATUS |=> o_cfg_rdata[15:0] == $past(cmd_q))
    else $error("command read does not show register");

  // Writes that do not address the command word must leave it untouched
  AST_IDENT_WRITE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_cfg_wr && i_cfg_dw == pch_pkg::DW_IDENT |=> cmd_q == $past(cmd_q))
    else $error("identity write disturbed command");

  AST_OTHER_WRITE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_cfg_wr && i_cfg_dw != pch_pkg::DW_CMD_STATUS |=> cmd_q == $past(cmd_q))
    else $error("foreign write disturbed command");

  AST_HIGH_LANE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    cmd_wr && !i_cfg_be[1] |=> cmd_q[15:8] == $past(cmd_q[15:8]))
    else $error("disabled upper lane was written");

  AST_SERR_WRITE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    cmd_wr && i_cfg_be[1] |=> cmd_q[pch_pkg::BIT_SYSTEM_ERROR_REPORT_ENABLE] == $past(i_cfg_wdata[8]))
    else $error("system error enable not written");

  AST_PARITY_WRITE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    cmd_wr && i_cfg_be[0] |=> cmd_q[pch_pkg::BIT_PARITY_EN] == $past(i_cfg_wdata[6]))
    else $error("parity response enable not written");

  // Hardwired bits never hold a one, whatever was written
  AST_RSVD_Q: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    cmd_q[pch_pkg::RSVD_MSB:pch_pkg::RSVD_LSB] == 6'h00)
    else $error("reserved command bits set");

  AST_B2B_Q: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !cmd_q[pch_pkg::BIT_B2B_EN])
    else $error("back-to-back bit set");

  AST_STEP_Q: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !cmd_q[pch_pkg::BIT_STEP_EN])
    else $error("stepping bit set");

  AST_PALETTE_Q: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !cmd_q[pch_pkg::BIT_PALETTE])
    else $error("palette snoop bit set");

  AST_WINV_Q: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !cmd_q[pch_pkg::BIT_WINV_EN])
    else $error("write-invalidate bit set");

  AST_SPECIAL_Q: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !cmd_q[pch_pkg::BIT_SPECIAL])
    else $error("special cycle bit set");

  // Error reporting in both directions
  AST_SERR_SET: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_addr_par_err && cmd_q[pch_pkg::BIT_SYSTEM_ERROR_REPORT_ENABLE] && cmd_q[pch_pkg::BIT_PARITY_EN] |=> o_serr)
    else $error("enabled address parity error not reported");

  AST_SERR_NOERR: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !i_addr_par_err |=> !o_serr)
    else $error("system error without address parity error");

  AST_SERR_NOEN: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !cmd_q[pch_pkg::BIT_SYSTEM_ERROR_REPORT_ENABLE] |=> !o_serr)
    else $error("system error while its enable is clear");

  AST_PERR_SET: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_data_par_err && cmd_q[pch_pkg::BIT_PARITY_EN] |=> o_perr)
    else $error("enabled data parity error not reported");

  AST_PERR_NOERR: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !i_data_par_err |=> !o_perr)
    else $error("parity error without data parity error");

  AST_DRV_FOLLOW: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    1'b1 |=> o_serr_drv_en == $past(cmd_q[pch_pkg::BIT_SYSTEM_ERROR_REPORT_ENABLE]))
    else $error("driver enable does not track its bit");

  // Space claims and bus requests in both directions
  AST_INIT_SET: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_bus_want && cmd_q[pch_pkg::BIT_INIT_EN] |=> o_bus_req)
    else $error("enabled initiator did not request");

  AST_WANT_OFF: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !i_bus_want |=> !o_bus_req)
    else $error("bus requested without a wish");

  AST_MEM_OFF: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    o_mem_claim |-> $past(cmd_q[pch_pkg::BIT_MEM_EN]) && $past(i_mem_hit))
    else $error("memory cycle claimed while disabled");

  AST_MEM_HIT_OFF: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !i_mem_hit |=> !o_mem_claim)
    else $error("memory claim without a hit");

  AST_IO_SET: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    i_io_hit && cmd_q[pch_pkg::BIT_IO_EN] |=> o_io_claim)
    else $error("enabled io hit not claimed");

  AST_IO_HIT_OFF: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !i_io_hit |=> !o_io_claim)
    else $error("io claim without a hit");

  // Reset clears every output, not only the command word
  AST_RESET_OUT: assert property (@(posedge I_CLK)
    !I_RST_B |=> !o_serr && !o_perr && !o_serr_drv_en && !o_cfg_ack
                 && o_cfg_rdata == 32'h0000_0000)
    else $error("outputs not cleared by reset");

endmodule

// file: verif/pch_host_model.sv
// Host model that issues configuration reads and writes
`timescale 1ns/100ps
module pch_host_model (
  input  wire logic        I_CLK,
  output logic             o_rd,
  output logic             o_wr,
  output logic [5:0]       o_dw,
  output logic [3:0]       o_be,
  output logic [31:0]      o_wdata,
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_ack
);
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_dw = 6'h00;
    o_be = 4'h0;
    o_wdata = 32'h0;
  end
  // Idle cycles before a request let the bench play a slow host
  task automatic access(input logic w, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, input int idle,
                        output logic [31:0] rd, output logic ack);
    repeat (idle) @(posedge I_CLK);
    @(posedge I_CLK);
    o_rd    <= ~w;
    o_wr    <= w;
    o_dw    <= dw;
    o_be    <= be;
    o_wdata <= wd;
    @(posedge I_CLK);
    o_rd    <= 1'b0;
    o_wr    <= 1'b0;
    // Released lines toggle so a stale value never passes for a held one
    o_dw    <= ~dw;
    o_be    <= ~be;
    o_wdata <= ~wd;
    #1;
    rd  = i_rdata;
    ack = i_ack;
  endtask
endmodule

// file: verif/tb_pci_config_id_and_command.sv
// Self-checking bench for the identity words and command register
`timescale 1ns/100ps
module tb_pci_config_id_and_command;
  logic        clk, rst_b, cfg_rd, cfg_wr, ack, ok, ape, dpe, mhit, ihit, want;
  logic        system_error_report_enable, serr, perr, mclaim, iclaim, breq;
  logic [5:0]  dw;
  logic [3:0]  be;
  logic [31:0] wdata, rdata, rd, r, wd;
  logic [15:0] cmd;
  logic [31:0] seed = 32'h00002439;
  int          error_cnt = 0, n_compared = 0, cycles = 0;
  // Arbitrary identity values, chosen only to be told apart
  localparam logic [15:0] MAKER = 16'hA5C3;
  localparam logic [15:0] PART  = 16'h3C5A;

  pch_config_regs #(.MAKER_ID(MAKER), .PART_ID(PART)) uut (.I_CLK(clk), .I_RST_B(rst_b),
    .i_cfg_rd(cfg_rd), .i_cfg_wr(cfg_wr), .i_cfg_dw(dw), .i_cfg_be(be), .i_cfg_wdata(wdata),
    .o_cfg_rdata(rdata), .o_cfg_ack(ack), .i_addr_par_err(ape), .i_data_par_err(dpe),
    .i_mem_hit(mhit), .i_io_hit(ihit), .i_bus_want(want), .o_serr_drv_en(system_error_report_enable),
    .o_serr(serr), .o_perr(perr), .o_mem_claim(mclaim), .o_io_claim(iclaim), .o_bus_req(breq));
  pch_host_model host (.I_CLK(clk), .o_rd(cfg_rd), .o_wr(cfg_wr), .o_dw(dw), .o_be(be),
    .o_wdata(wdata), .i_rdata(rdata), .i_ack(ack));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] next_cmd(logic [15:0] old, logic [3:0] b, logic [31:0] w);
    logic [15:0] m;
    m = {{8{b[1]}}, {8{b[0]}}};
    return ((old & ~m) | (w[15:0] & m)) & pch_pkg::CMD_WRITABLE;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // The whole run needs about 500 cycles; a hang is cut well after that
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    rst_b = 1'b0;
    {ape, dpe, mhit, ihit, want} = 5'h00;
    cmd = pch_pkg::CMD_RESET;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    host.access(1'b0, 6'h01, 4'hF, 32'h0, 0, rd, ok);
    chk(rd, 32'h0);
    host.access(1'b1, 6'h00, 4'hF, 32'hFFFFFFFF, 1, rd, ok);
    chk(ok, 1'b1);
    host.access(1'b1, 6'h05, 4'hF, 32'hFFFFFFFF, 2, rd, ok);
    host.access(1'b0, 6'h00, 4'hF, 32'h0, 0, rd, ok);
    chk(rd, {PART, MAKER});
    host.access(1'b0, 6'h05, 4'hF, 32'h0, 0, rd, ok);
    chk(rd, 32'h0);
    for (int i = 0; i < 60; i++) begin
      r  = rnd();
      wd = (i == 0) ? 32'hFFFFFFFF : rnd();
      host.access(1'b1, 6'h01, (i == 0) ? 4'hF : r[3:0], wd, int'(r[5:4]), rd, ok);
      cmd = next_cmd(cmd, (i == 0) ? 4'hF : r[3:0], wd);
      host.access(1'b0, 6'h01, 4'hF, 32'h0, 0, rd, ok);
      chk(rd, {16'h0000, cmd});
      chk(ok, 1'b1);
      @(posedge clk);
      {ape, dpe, mhit, ihit, want} <= r[12:8];
      @(posedge clk);
      ape <= 1'b0;
      dpe <= 1'b0;
      #1;
      chk({system_error_report_enable, serr, perr}, {cmd[8], r[12] & cmd[8] & cmd[6], r[11] & cmd[6]});
      chk({mclaim, iclaim, breq}, {r[10] & cmd[1], r[9] & cmd[0], r[8] & cmd[2]});
    end
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk({system_error_report_enable, serr, perr, mclaim, iclaim, breq, ack}, 7'h00);
    host.access(1'b0, 6'h01, 4'hF, 32'h0, 0, rd, ok);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule
